// ===== rtl/bcmd_cfg.svh
// constants for the bridge command register block
// assumes byte offsets on the configuration port, 16-bit data
`ifndef BCMD_CFG_SVH
`define BCMD_CFG_SVH
`define BCMD_OFS_COMMAND 8'h04
`define BCMD_OFS_STATUS 8'h06
`define BCMD_OFS_EVENT 8'h08
`define BCMD_CMD_RESET 16'h0000
`define BCMD_CMD_RW_MASK 16'h0157
`define BCMD_BIT_IO 0
`define BCMD_BIT_MEM 1
`define BCMD_BIT_MASTER 2
`define BCMD_BIT_MWI 4
`define BCMD_BIT_PARITY 6
`define BCMD_BIT_SERR 8
`define BCMD_STS_PARITY 8
`define BCMD_STS_SYSERR 14
`define BCMD_STS_RESET 16'h0010
`define BCMD_STS_CLR_MASK 16'h4100
`endif

// ===== rtl/bcmd_pkg.sv
// types shared by the bridge command register block
// assumes bcmd_cfg.svh is on the include path
package bcmd_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bcmd_bus_s;
  typedef enum logic [1:0] {
    BCMD_REQ_NONE,
    BCMD_REQ_MEM,
    BCMD_REQ_IO
  } bcmd_req_e;
  typedef struct packed {
    logic io_en;
    logic mem_en;
    logic master_en;
    logic mwi_en;
    logic parity_en;
    logic serr_en;
  } bcmd_ctl_s;
endpackage : bcmd_pkg

// ===== rtl/bcmd_gate.sv
// gating of bridge traffic by the command register controls
// assumes all event inputs are one-cycle pulses on clock
`timescale 1ns/100ps
module bcmd_gate (
  input wire bcmd_pkg::bcmd_ctl_s ctl,
  input wire bcmd_pkg::bcmd_req_e dn_req,
  input wire dn_write,
  input wire dn_poisoned,
  input wire sec_cycle,
  input wire sec_serr,
  input wire up_cpl_poisoned,
  input wire dn_wr_poisoned,
  output logic dn_accept,
  output logic dn_unsupported,
  output logic dn_promote_mwi,
  output logic dn_bad_parity,
  output logic up_forward,
  output logic sec_claim,
  output logic err_msg_send,
  output logic set_parity_flag,
  output logic set_syserr_flag
);
  import bcmd_pkg::*;
  always_comb begin
    dn_accept = 1'b0;
    case (dn_req)
      BCMD_REQ_MEM: dn_accept = ctl.mem_en; // [RL14] [RL15]
      BCMD_REQ_IO: dn_accept = ctl.io_en; // [RL16] [RL17]
      default: dn_accept = 1'b0;
    endcase
    dn_unsupported = (dn_req != BCMD_REQ_NONE) && !dn_accept; // [RL14] [RL16]
    // promotion applies only to accepted memory writes
    dn_promote_mwi = ctl.mwi_en && dn_accept && dn_write &&
                     (dn_req == BCMD_REQ_MEM); // [RL10]
    // poison travels on whatever parity response says
    dn_bad_parity = dn_accept && dn_poisoned; // [RL8]
    up_forward = ctl.master_en && sec_cycle; // [RL12] [RL13]
    sec_claim = ctl.master_en && sec_cycle; // [RL12]
    err_msg_send = ctl.serr_en && sec_serr; // [RL5]
    set_syserr_flag = err_msg_send; // [RL19]
    set_parity_flag = ctl.parity_en &&
                      (up_cpl_poisoned || dn_wr_poisoned); // [RL7] [RL18]
  end
endmodule : bcmd_gate

// ===== rtl/bcmd_top.sv
// bridge command register with the two status flags it drives
// assumes a single-cycle register port, read data one cycle later
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`include "bcmd_cfg.svh"
// Contract
// [RL1] command at offset 04h, 16 bits, resets zero
// [RL2] bits 15 to 11 read zero
// [RL3] interrupt mask bit 10 reads zero
// [RL4] back-to-back bit 9 reads zero
// [RL5] bit 8 gates upstream error messages
// [RL6] stepping bit 7 hardwired zero
// [RL7] bit 6 gates master parity flag setting
// [RL8] poisoned packets always forwarded bad parity
// [RL9] palette snoop bit 5 reads zero
// [RL10] bit 4 promotes writes to invalidate
// [RL11] special cycle bit 3 reads zero
// [RL12] bit 2 clear blocks upstream and secondary
// [RL13] bit 2 set allows upstream forwarding
// [RL14] bit 1 clear answers memory unsupported
// [RL15] bit 1 set accepts memory requests
// [RL16] bit 0 clear answers I/O unsupported
// [RL17] bit 0 set accepts I/O requests
// [RL18] parity flag only with enable and poison
// [RL19] system error flag on sent messages
// [RL20] writes to fixed bits are discarded
module bcmd_top (
  input wire clock,
  input wire sys_rst,
  input wire bcmd_pkg::bcmd_bus_s bus,
  output logic [15:0] rdata,
  input wire bcmd_pkg::bcmd_req_e dn_req,
  input wire dn_write,
  input wire dn_poisoned,
  input wire sec_cycle,
  input wire sec_serr,
  input wire up_cpl_poisoned,
  input wire dn_wr_poisoned,
  output logic dn_accept,
  output logic dn_unsupported,
  output logic dn_promote_mwi,
  output logic dn_bad_parity,
  output logic up_forward,
  output logic sec_claim,
  output logic err_msg_send,
  output logic write_invalidate_promote_en,
  output logic upstream_initiate_en,
  output logic mem_space_decode_en,
  output logic io_space_decode_en,
  output logic parity_response_en,
  output logic system_error_report_en,
  output logic master_parity_err_flag,
  output logic signaled_flag_a
);
  import bcmd_pkg::*;

  logic [15:0] cmd;
  logic [15:0] next_cmd;
  logic [15:0] sts;
  logic [15:0] next_sts;
  logic [15:0] next_rdata;
  bcmd_ctl_s ctl;
  logic set_parity_flag;
  logic set_syserr_flag;

  function automatic logic [15:0] cmd_view(input logic [15:0] c);
    // fixed and reserved bits never leave the register as ones
    cmd_view = c & `BCMD_CMD_RW_MASK; // [RL2] [RL3] [RL4] [RL6] [RL9] [RL11]
  endfunction : cmd_view

  assign ctl.io_en = cmd[`BCMD_BIT_IO];
  assign ctl.mem_en = cmd[`BCMD_BIT_MEM];
  assign ctl.master_en = cmd[`BCMD_BIT_MASTER];
  assign ctl.mwi_en = cmd[`BCMD_BIT_MWI];
  assign ctl.parity_en = cmd[`BCMD_BIT_PARITY];
  assign ctl.serr_en = cmd[`BCMD_BIT_SERR];

  always_comb begin
    next_cmd = cmd;
    next_sts = sts;
    next_rdata = 16'h0000;
    if (bus.wr && bus.addr == `BCMD_OFS_COMMAND) begin
      next_cmd = cmd_view(bus.wdata); // [RL1] [RL20]
    end
    // write one to clear; a set in the same cycle wins
    if (bus.wr && bus.addr == `BCMD_OFS_STATUS) begin
      next_sts = sts & ~(bus.wdata & `BCMD_STS_CLR_MASK);
    end
    if (set_parity_flag) begin
      next_sts[`BCMD_STS_PARITY] = 1'b1; // [RL7] [RL18]
    end
    if (set_syserr_flag) begin
      next_sts[`BCMD_STS_SYSERR] = 1'b1; // [RL19]
    end
    if (bus.rd) begin
      if (bus.addr == `BCMD_OFS_COMMAND) begin
        next_rdata = cmd_view(cmd); // [RL2]
      end else if (bus.addr == `BCMD_OFS_STATUS) begin
        next_rdata = sts;
      end else begin
        next_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd <= `BCMD_CMD_RESET; // [RL1]
      sts <= `BCMD_STS_RESET;
      rdata <= 16'h0000;
    end else begin
      cmd <= next_cmd;
      sts <= next_sts;
      rdata <= next_rdata;
    end
  end

  bcmd_gate u_gate (
    .ctl(ctl),
    .dn_req(dn_req),
    .dn_write(dn_write),
    .dn_poisoned(dn_poisoned),
    .sec_cycle(sec_cycle),
    .sec_serr(sec_serr),
    .up_cpl_poisoned(up_cpl_poisoned),
    .dn_wr_poisoned(dn_wr_poisoned),
    .dn_accept(dn_accept),
    .dn_unsupported(dn_unsupported),
    .dn_promote_mwi(dn_promote_mwi),
    .dn_bad_parity(dn_bad_parity),
    .up_forward(up_forward),
    .sec_claim(sec_claim),
    .err_msg_send(err_msg_send),
    .set_parity_flag(set_parity_flag),
    .set_syserr_flag(set_syserr_flag)
  );

  assign io_space_decode_en = ctl.io_en;
  assign mem_space_decode_en = ctl.mem_en;
  assign upstream_initiate_en = ctl.master_en;
  assign write_invalidate_promote_en = ctl.mwi_en;
  assign parity_response_en = ctl.parity_en;
  assign system_error_report_en = ctl.serr_en;
  assign master_parity_err_flag = sts[`BCMD_STS_PARITY];
  assign signaled_flag_a = sts[`BCMD_STS_SYSERR];
endmodule : bcmd_top

// ===== verif/bcmd_checker.sv
// port assertions for the bridge command register
// assumes a bind onto bcmd_top, one clock domain
`timescale 1ns/100ps
module bcmd_checker (
  input wire clock,
  input wire sys_rst,
  input wire bcmd_pkg::bcmd_bus_s bus,
  input wire [15:0] rdata,
  input wire bcmd_pkg::bcmd_req_e dn_req,
  input wire dn_poisoned,
  input wire sec_cycle,
  input wire sec_serr,
  input wire dn_accept,
  input wire dn_unsupported,
  input wire dn_bad_parity,
  input wire up_forward,
  input wire err_msg_send,
  input wire upstream_initiate_en,
  input wire mem_space_decode_en,
  input wire io_space_decode_en,
  input wire parity_response_en,
  input wire system_error_report_en,
  input wire master_parity_err_flag,
  input wire signaled_flag_a
);
  import bcmd_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence cmd_read;
    bus.rd && bus.addr == 8'h04;
  endsequence
  fixed_zero_a: assert property (
    cmd_read |=> (rdata & 16'hfea8) == 16'h0) else $error("fixed bits set");
  mem_refuse_a: assert property (
    dn_req == BCMD_REQ_MEM && !mem_space_decode_en |-> dn_unsupported
    && !dn_accept) else $error("memory not refused");
  io_refuse_a: assert property (
    dn_req == BCMD_REQ_IO && !io_space_decode_en |-> dn_unsupported
    && !dn_accept) else $error("io not refused");
  fwd_gate_a: assert property (
    sec_cycle |-> up_forward == upstream_initiate_en) else $error("fwd");
  bad_par_a: assert property (
    dn_accept && dn_poisoned |-> dn_bad_parity) else $error("parity");
  err_msg_a: assert property (
    sec_serr |-> err_msg_send == system_error_report_en) else $error("msg");
  sys_flag_a: assert property (
    err_msg_send |=> signaled_flag_a) else $error("error flag not set");
  par_flag_a: assert property (
    $rose(master_parity_err_flag) |-> $past(parity_response_en))
    else $error("parity flag set while disabled");
endmodule : bcmd_checker

// ===== verif/bcmd_host.sv
// host configuration software model on the register port
// assumes read data stands only in the cycle after the read
`timescale 1ns/100ps
module bcmd_host (
  input wire clock,
  input wire [15:0] rdata,
  output bcmd_pkg::bcmd_bus_s bus
);
  import bcmd_pkg::*;
  initial bus = '0;
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    // sampled before this edge's update lands
    @(posedge clock);
    d = rdata;
  endtask : rd
endmodule : bcmd_host

// ===== verif/test_bridge_command_register.sv
// self-checking bench for the bridge command register
// assumes the host model owns the register port
`timescale 1ns/100ps
module test_bridge_command_register;
  import bcmd_pkg::*;
  logic clock = 0;
  logic sys_rst = 1;
  wire bcmd_bus_s bus;
  bcmd_req_e dn_req = BCMD_REQ_NONE;
  logic [5:0] ins = '0;
  logic [15:0] rdata, d;
  wire dn_write, dn_poisoned, sec_cycle, sec_serr;
  wire up_cpl_poisoned, dn_wr_poisoned;
  logic dn_accept, dn_unsupported, dn_promote_mwi, dn_bad_parity;
  logic up_forward, sec_claim, err_msg_send, write_invalidate_promote_en;
  logic upstream_initiate_en, mem_space_decode_en, io_space_decode_en;
  logic parity_response_en, system_error_report_en;
  logic master_parity_err_flag, signaled_flag_a;
  int fails = 0;
  int n_compared = 0;
  assign {dn_write, dn_poisoned, sec_cycle, sec_serr} = ins[5:2];
  assign {up_cpl_poisoned, dn_wr_poisoned} = ins[1:0];
  always #5 clock = ~clock;
  bcmd_top dut_u (.*);
  bcmd_host host_u (.*);
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task ev(input bcmd_req_e r, input logic [5:0] i, input logic [6:0] e);
    @(posedge clock);
    dn_req <= r;
    ins <= i;
    #5 chk("traffic", {9'h0, e}, {9'h0, dn_accept, dn_unsupported,
      dn_promote_mwi, dn_bad_parity, up_forward, sec_claim, err_msg_send});
    @(posedge clock);
    dn_req <= BCMD_REQ_NONE;
    ins <= '0;
  endtask : ev
  task t_gate_off;
    host_u.rd(8'h04, d);
    chk("command", 16'h0000, d);
    ev(BCMD_REQ_MEM, 6'h00, 7'b0100000);
    ev(BCMD_REQ_IO, 6'h00, 7'b0100000);
    ev(BCMD_REQ_NONE, 6'h0c, 7'h00);
    ev(BCMD_REQ_NONE, 6'h02, 7'h00);
    host_u.rd(8'h06, d);
    chk("status", 16'h0010, d);
    host_u.wr(8'h04, 16'h0002);
    ev(BCMD_REQ_MEM, 6'h10, 7'b1001000);
    ev(BCMD_REQ_MEM, 6'h30, 7'b1001000);
  endtask : t_gate_off
  task t_gate_on;
    host_u.wr(8'h04, 16'hffff);
    host_u.rd(8'h04, d);
    chk("command", 16'h0157, d);
    chk("enables", 16'h003f, {10'h0, write_invalidate_promote_en,
      upstream_initiate_en, mem_space_decode_en, io_space_decode_en,
      parity_response_en, system_error_report_en});
    host_u.rd(8'h40, d);
    chk("unmapped", 16'h0000, d);
    ev(BCMD_REQ_MEM, 6'h30, 7'b1011000);
    ev(BCMD_REQ_IO, 6'h00, 7'b1000000);
    ev(BCMD_REQ_NONE, 6'h0c, 7'b0000111);
    ev(BCMD_REQ_NONE, 6'h02, 7'h00);
    host_u.rd(8'h06, d);
    chk("status", 16'h4110, d);
    chk("flags", 16'h0003, {14'h0, signaled_flag_a,
      master_parity_err_flag});
    host_u.wr(8'h06, 16'h4100);
    host_u.rd(8'h06, d);
    chk("status", 16'h0010, d);
  endtask : t_gate_on
  // mid-run reset must drop every control bit again
  task t_reset;
    host_u.wr(8'h04, 16'hffff);
    @(posedge clock);
    sys_rst <= 1;
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    host_u.rd(8'h04, d);
    chk("command", 16'h0000, d);
    chk("enables", 16'h0000, {10'h0, write_invalidate_promote_en,
      upstream_initiate_en, mem_space_decode_en, io_space_decode_en,
      parity_response_en, system_error_report_en});
    host_u.rd(8'h06, d);
    chk("status", 16'h0010, d);
  endtask : t_reset
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 0;
    t_gate_off;
    t_gate_on;
    t_reset;
    give_verdict;
  end
  initial begin
    #20000;
    fails++;
    give_verdict;
  end
endmodule : test_bridge_command_register
bind bcmd_top bcmd_checker chk_u (.*);
